// ==== srap_pkg.sv ====
// package for the serial register access port: constants, states, byte kinds
// assumes a single clock domain on mclk; all link pins are synchronised before use
// Functional notes
// [R1] two-wire start: data falls while clock high, repeated start included
// [R2] two-wire stop: data rises while clock high, engine returns to idle
// [R3] acknowledge: receiver holds data low through the ninth clock high time
// [R4] master reads by first writing address, write flag, then register index
// [R5] after index acknowledge master repeats start with address and read flag
// [R6] on address with read flag device acknowledges then drives selected register
// [R7] master ends read with not-acknowledge then stop; device releases data
// [R8] data left high on ninth clock is a not-acknowledge, ending the read
// [R9] four-wire master drives chip select low for a transfer, high after
// [R10] serial data output stays released whenever the device is not selected
// [R11] four-wire bytes shift most significant bit first, address and data alike
// [R12] four-wire data is sampled on the rising serial clock edge
// [R13] four-wire driven data changes on the falling serial clock edge
// [R14] master keeps four-wire clock at most 1MHz for full access; the bench host clocks at 6.25MHz (160 ns period)
// [R15] four-wire transfers take at least 16 clocks, two bytes or more
// [R16] first four-wire byte is address, all following bytes are data
// [R17] first address bit gives direction: 1 read, 0 write
// [R18] remaining seven address bits give register index A6 down to A0
// [R19] device accepts single and burst four-wire reads and writes
// [R20] master selects only one slave at a time
// [R21] two-wire write: address+write, index, data bytes, each acknowledged; the code not-acknowledges a data byte while the write buffer is full
// [R22] two-wire burst write increments register index after each data byte; the code does not increment it for a byte refused while the buffer is full
// [R23] two-wire address is 110100 followed by the address select pin level
// [R24] two-wire burst read: each master acknowledge advances to the next register
// [R25] four-wire bursts increment register index after each data byte
package srap_pkg;
  localparam int BYTE_BITS = 8;
  localparam int INDEX_BITS = 7;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_WIDTH = INDEX_BITS + BYTE_BITS;
  // upper six bits of the two-wire device address, low bit from the pin
  localparam logic [5:0] DEV_ADDR_HI = 6'h34;
  // two-wire bit count at which a byte is complete
  localparam logic [3:0] I2C_BYTE_DONE = 4'h8;
  // four-wire bit position of the last bit in a byte
  localparam logic [2:0] SPI_LAST_BIT = 3'h7;
  // resting levels of the pins while nothing drives them
  localparam logic PIN_IDLE = 1'b1;
  localparam logic [6:0] INDEX_RESET = 7'h00;

  typedef enum logic [2:0] {
    I2C_IDLE,
    I2C_RX,
    I2C_RACK,
    I2C_TX,
    I2C_TACK,
    I2C_WAIT
  } srap_i2c_state_t;

  typedef enum logic [1:0] {
    KIND_ADDR,
    KIND_INDEX,
    KIND_DATA
  } srap_byte_kind_t;
endpackage : srap_pkg

// ==== srap_sync.sv ====
// two-stage synchroniser for pins arriving from outside the mclk domain
// assumes a synchronous active-high reset; reset value is the pin's resting level
`timescale 1ns/1ps
module srap_sync #(
  parameter int WIDTH = 1,
  parameter logic RESET_VAL = 1'b1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // asynchronous input and its synchronised copy
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge mclk) begin
    if (srst) begin
      meta_q <= {WIDTH{RESET_VAL}};
      sync_out <= {WIDTH{RESET_VAL}};
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : srap_sync

// ==== srap_fifo.sv ====
// write-request buffer between the serial engines and the register file
// assumes DEPTH is a power of two; single clock, synchronous reset
`timescale 1ns/1ps
module srap_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0] wr_ptr_q;
  logic [PW:0] rd_ptr_q;
  logic do_push;
  logic do_pop;

  // full when pointers differ only in the wrap bit
  assign in_ready = !((wr_ptr_q[PW] != rd_ptr_q[PW]) && (wr_ptr_q[PW-1:0] == rd_ptr_q[PW-1:0]));
  assign out_valid = (wr_ptr_q != rd_ptr_q);
  assign out_data = mem[rd_ptr_q[PW-1:0]];
  assign do_push = in_valid && in_ready;
  assign do_pop = out_valid && out_ready;

  // storage array
  always_ff @(posedge mclk) begin
    if (do_push) begin
      mem[wr_ptr_q[PW-1:0]] <= in_data;
    end
  end

  // pointers
  always_ff @(posedge mclk) begin
    if (srst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end
endmodule : srap_fifo

// ==== srap_top.sv ====
// serial register access port: two-wire and four-wire slave engines
// assumes the register file answers rd_data combinationally from rd_index on mclk,
// and drains write requests through reg_wr_valid / reg_wr_ready
`timescale 1ns/1ps
module srap_top (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // serial clock pin, shared by both protocols
  input wire logic scl_in,
  // two-wire data / four-wire data input pin
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // four-wire chip select, active low
  input wire logic cs_n_in,
  // address select input / four-wire data output pin
  input wire logic address_select_pin,
  output logic sdo_out,
  output logic sdo_oe_n,
  // register write requests
  output logic reg_wr_valid,
  input wire logic reg_wr_ready,
  output logic [6:0] reg_wr_index,
  output logic [7:0] reg_wr_data,
  // register read port
  output logic [6:0] rd_index,
  input wire logic [7:0] rd_data,
  // status
  output logic wr_dropped,
  output logic link_busy
);
  // synchronised pins
  logic scl_s;
  logic sda_s;
  logic cs_n_s;
  logic ad_s;
  logic scl_d_q;
  logic sda_d_q;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic spi_sel;

  // two-wire engine state
  srap_pkg::srap_i2c_state_t i2c_st_q;
  srap_pkg::srap_byte_kind_t i2c_kind_q;
  logic [3:0] i2c_cnt_q;
  logic [7:0] i2c_sh_q;
  logic i2c_rw_q;
  logic i2c_mack_q;
  logic [6:0] i2c_idx_q;
  logic i2c_push_q;
  logic [14:0] i2c_pdata_q;
  logic sda_oe_n_q;

  // four-wire engine state
  logic spi_first_q;
  logic [2:0] spi_cnt_q;
  logic [7:0] spi_sh_q;
  logic [7:0] spi_osh_q;
  logic spi_rw_q;
  logic [6:0] spi_idx_q;
  logic spi_push_q;
  logic [14:0] spi_pdata_q;
  logic sdo_out_q;
  logic sdo_oe_n_q;
  logic wr_dropped_q;

  // shared outputs
  logic [6:0] rd_index_q;
  logic link_busy_q;
  logic sda_out_q;
  logic push_valid;
  logic push_ready;
  logic [14:0] push_data;
  logic [14:0] fifo_out;
  logic [7:0] spi_byte;

  // pins pass two flip-flops before any logic sees them
  srap_sync #(
    .WIDTH(4),
    .RESET_VAL(srap_pkg::PIN_IDLE)
  ) u_sync (
    .mclk(mclk),
    .srst(srst),
    .async_in({scl_in, sda_in, cs_n_in, address_select_pin}),
    .sync_out({scl_s, sda_s, cs_n_s, ad_s})
  );

  // delayed copies for edge detection
  always_ff @(posedge mclk) begin
    if (srst) begin
      scl_d_q <= srap_pkg::PIN_IDLE;
      sda_d_q <= srap_pkg::PIN_IDLE;
    end else begin
      scl_d_q <= scl_s;
      sda_d_q <= sda_s;
    end
  end

  // edges of the serial clock and bus conditions
  assign scl_rise = scl_s && !scl_d_q;
  assign scl_fall = !scl_s && scl_d_q;
  assign start_det = scl_s && scl_d_q && sda_d_q && !sda_s; // R1
  assign stop_det = scl_s && scl_d_q && !sda_d_q && sda_s; // R2
  assign spi_sel = !cs_n_s; // R9
  assign spi_byte = {spi_sh_q[6:0], sda_s};

  // two-wire engine; held idle while the four-wire select is active
  always_ff @(posedge mclk) begin
    if (srst || spi_sel) begin
      i2c_st_q <= srap_pkg::I2C_IDLE;
      i2c_kind_q <= srap_pkg::KIND_ADDR;
      i2c_cnt_q <= '0;
      i2c_sh_q <= '0;
      i2c_rw_q <= 1'b0;
      i2c_mack_q <= 1'b0;
      i2c_push_q <= 1'b0;
      i2c_pdata_q <= '0;
      sda_oe_n_q <= 1'b1;
      if (srst) begin
        i2c_idx_q <= srap_pkg::INDEX_RESET;
      end
    end else begin
      i2c_push_q <= 1'b0;
      if (start_det) begin
        // start or repeated start: expect an address byte
        i2c_st_q <= srap_pkg::I2C_RX; // R1
        i2c_kind_q <= srap_pkg::KIND_ADDR;
        i2c_cnt_q <= '0;
        sda_oe_n_q <= 1'b1;
      end else if (stop_det) begin
        i2c_st_q <= srap_pkg::I2C_IDLE; // R2
        sda_oe_n_q <= 1'b1; // R7
      end else begin
        unique case (i2c_st_q)
          srap_pkg::I2C_IDLE, srap_pkg::I2C_WAIT: begin
            sda_oe_n_q <= 1'b1;
          end
          srap_pkg::I2C_RX: begin
            if (scl_rise) begin
              i2c_sh_q <= {i2c_sh_q[6:0], sda_s};
              i2c_cnt_q <= i2c_cnt_q + 4'h1;
            end else if (scl_fall && i2c_cnt_q == srap_pkg::I2C_BYTE_DONE) begin
              i2c_cnt_q <= '0;
              i2c_st_q <= srap_pkg::I2C_RACK;
              unique case (i2c_kind_q)
                srap_pkg::KIND_ADDR: begin
                  if (i2c_sh_q[7:1] == {srap_pkg::DEV_ADDR_HI, ad_s}) begin // R23
                    sda_oe_n_q <= 1'b0; // R3
                    i2c_rw_q <= i2c_sh_q[0]; // R6
                    if (!i2c_sh_q[0]) begin
                      i2c_kind_q <= srap_pkg::KIND_INDEX; // R4
                    end
                  end else begin
                    i2c_st_q <= srap_pkg::I2C_WAIT;
                  end
                end
                srap_pkg::KIND_INDEX: begin
                  sda_oe_n_q <= 1'b0; // R21
                  i2c_idx_q <= i2c_sh_q[6:0]; // R5
                  i2c_kind_q <= srap_pkg::KIND_DATA;
                end
                default: begin
                  // data byte: refused with a not-acknowledge when the buffer is full
                  if (push_ready) begin
                    sda_oe_n_q <= 1'b0; // R21
                    i2c_push_q <= 1'b1;
                    i2c_pdata_q <= {i2c_idx_q, i2c_sh_q};
                    i2c_idx_q <= i2c_idx_q + 7'h01; // R22
                  end
                end
              endcase
            end
          end
          srap_pkg::I2C_RACK: begin
            if (scl_fall) begin
              if (i2c_kind_q == srap_pkg::KIND_ADDR && i2c_rw_q) begin
                // first read byte goes out right after the address acknowledge
                i2c_sh_q <= rd_data; // R6
                sda_oe_n_q <= rd_data[7];
                i2c_st_q <= srap_pkg::I2C_TX;
              end else begin
                sda_oe_n_q <= 1'b1;
                i2c_st_q <= srap_pkg::I2C_RX;
              end
            end
          end
          srap_pkg::I2C_TX: begin
            if (scl_fall) begin
              if (i2c_cnt_q == 4'h7) begin
                // release for the master's acknowledge bit
                sda_oe_n_q <= 1'b1;
                i2c_cnt_q <= '0;
                i2c_st_q <= srap_pkg::I2C_TACK;
              end else begin
                i2c_cnt_q <= i2c_cnt_q + 4'h1;
                i2c_sh_q <= {i2c_sh_q[6:0], 1'b0};
                sda_oe_n_q <= i2c_sh_q[6];
              end
            end
          end
          srap_pkg::I2C_TACK: begin
            if (scl_rise) begin
              i2c_mack_q <= !sda_s; // R8
              if (!sda_s) begin
                i2c_idx_q <= i2c_idx_q + 7'h01; // R24
              end
            end else if (scl_fall) begin
              if (i2c_mack_q) begin
                i2c_sh_q <= rd_data; // R24
                sda_oe_n_q <= rd_data[7];
                i2c_st_q <= srap_pkg::I2C_TX;
              end else begin
                i2c_st_q <= srap_pkg::I2C_WAIT; // R7
              end
            end
          end
          default: begin
            i2c_st_q <= srap_pkg::I2C_IDLE;
          end
        endcase
      end
    end
  end

  // four-wire engine; a deselect aborts any partial byte
  always_ff @(posedge mclk) begin
    if (srst || !spi_sel) begin
      spi_first_q <= 1'b1;
      spi_cnt_q <= '0;
      spi_sh_q <= '0;
      spi_osh_q <= '0;
      spi_rw_q <= 1'b0;
      spi_push_q <= 1'b0;
      spi_pdata_q <= '0;
      sdo_out_q <= 1'b0;
      wr_dropped_q <= 1'b0;
      if (srst) begin
        spi_idx_q <= srap_pkg::INDEX_RESET;
      end
    end else begin
      spi_push_q <= 1'b0;
      wr_dropped_q <= 1'b0;
      if (scl_rise) begin
        spi_sh_q <= spi_byte; // R11 R12
        spi_cnt_q <= spi_cnt_q + 3'h1;
        if (spi_cnt_q == srap_pkg::SPI_LAST_BIT) begin
          if (spi_first_q) begin
            spi_first_q <= 1'b0; // R16
            spi_rw_q <= spi_byte[7]; // R17
            spi_idx_q <= spi_byte[6:0]; // R18
          end else begin
            if (!spi_rw_q) begin
              if (push_ready) begin
                spi_push_q <= 1'b1; // R19
                spi_pdata_q <= {spi_idx_q, spi_byte};
              end else begin
                wr_dropped_q <= 1'b1;
              end
            end
            spi_idx_q <= spi_idx_q + 7'h01; // R25
          end
        end
      end else if (scl_fall && !spi_first_q && spi_rw_q) begin
        if (spi_cnt_q == 3'h0) begin
          // byte boundary: fetch the register at the current index
          sdo_out_q <= rd_data[7]; // R13 R15
          spi_osh_q <= {rd_data[6:0], 1'b0};
        end else begin
          sdo_out_q <= spi_osh_q[7]; // R11 R13
          spi_osh_q <= {spi_osh_q[6:0], 1'b0};
        end
      end
    end
  end

  // data output drives only while selected
  always_ff @(posedge mclk) begin
    if (srst) begin
      sdo_oe_n_q <= 1'b1;
    end else begin
      sdo_oe_n_q <= cs_n_s; // R10 R20
    end
  end

  // read index, busy flag and the constant open-drain level
  always_ff @(posedge mclk) begin
    if (srst) begin
      rd_index_q <= srap_pkg::INDEX_RESET;
      link_busy_q <= 1'b0;
      sda_out_q <= 1'b0;
    end else begin
      rd_index_q <= spi_sel ? spi_idx_q : i2c_idx_q;
      link_busy_q <= spi_sel || (i2c_st_q != srap_pkg::I2C_IDLE);
      sda_out_q <= 1'b0;
    end
  end

  // only one engine runs at a time, so the pushes never collide
  assign push_valid = i2c_push_q || spi_push_q;
  assign push_data = i2c_push_q ? i2c_pdata_q : spi_pdata_q;

  srap_fifo #(
    .WIDTH(srap_pkg::FIFO_WIDTH),
    .DEPTH(srap_pkg::FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .srst(srst),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_data),
    .out_valid(reg_wr_valid),
    .out_ready(reg_wr_ready),
    .out_data(fifo_out)
  );

  assign reg_wr_index = fifo_out[14:8];
  assign reg_wr_data = fifo_out[7:0];
  assign rd_index = rd_index_q;
  assign sda_out = sda_out_q;
  assign sda_oe_n = sda_oe_n_q;
  assign sdo_out = sdo_out_q;
  assign sdo_oe_n = sdo_oe_n_q;
  assign wr_dropped = wr_dropped_q;
  assign link_busy = link_busy_q;
endmodule : srap_top

// ==== srap_assertions.sv ====
// pin-level checks of the serial register access port
// assumes pins are synchronised within four mclk cycles
`timescale 1ns/1ps
module srap_assertions (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // link pins
  input wire logic scl_in,
  input wire logic cs_n_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic sdo_out,
  input wire logic sdo_oe_n,
  // write port and status
  input wire logic reg_wr_valid,
  input wire logic reg_wr_ready,
  input wire logic [6:0] reg_wr_index,
  input wire logic [7:0] reg_wr_data,
  input wire logic wr_dropped,
  input wire logic link_busy
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  logic scl_q;
  logic [3:0] since_fall_q;
  // cycles since the serial clock last fell
  always_ff @(posedge mclk) begin
    scl_q <= scl_in;
    if (srst || (scl_q && !scl_in)) since_fall_q <= 4'h0;
    else if (since_fall_q != 4'hf) since_fall_q <= since_fall_q + 4'h1;
  end
  a_sdo_released: assert property (cs_n_in [*4] |-> sdo_oe_n)
    else $error("sdo driven while deselected");
  a_sdo_driven: assert property ($fell(cs_n_in) |-> ##[1:4] !sdo_oe_n)
    else $error("sdo not enabled after select");
  a_sda_only_low: assert property (!sda_oe_n |-> !sda_out)
    else $error("data pin driven high");
  a_ack_scl_low: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("data pull changed while clock high");
  a_twowire_quiet: assert property (!cs_n_in [*4] |-> sda_oe_n)
    else $error("two-wire pull while four-wire selected");
  a_sdo_on_fall: assert property
    (!sdo_oe_n && !$past(sdo_oe_n) && $changed(sdo_out) |-> since_fall_q <= 4'h6)
    else $error("sdo changed away from a clock fall");
  a_wr_held: assert property (reg_wr_valid && !reg_wr_ready |=>
    reg_wr_valid && $stable({reg_wr_index, reg_wr_data}))
    else $error("write word changed before taken");
  a_busy_sel: assert property (!sdo_oe_n [*2] |-> link_busy)
    else $error("busy low while selected");
  c_ack: cover property ($fell(sda_oe_n));
  c_sdo_high: cover property (!sdo_oe_n && sdo_out);
  c_drop: cover property (wr_dropped);
  c_write: cover property (reg_wr_valid && reg_wr_ready);
endmodule : srap_assertions

bind srap_top srap_assertions u_chk (.mclk, .srst, .scl_in, .cs_n_in, .sda_out, .sda_oe_n,
  .sdo_out, .sdo_oe_n, .reg_wr_valid, .reg_wr_ready, .reg_wr_index, .reg_wr_data,
  .wr_dropped, .link_busy);

// ==== srap_host.sv ====
// host master model for both link protocols
// assumes the bench resolves pins; half link period is 8 mclk (160 ns period)
`timescale 1ns/1ps
module srap_host (
  // system clock
  input wire logic mclk,
  // resolved pin levels
  input wire logic sda_line,
  input wire logic sdo_line,
  // driven pins
  output logic scl,
  output logic sda_drv,
  output logic cs_n
);
  // idle: clock high, data released to the pull-up
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
    cs_n = 1'b1;
  end
  // half link period; the engines sample with mclk, so a slower master only widens margins
  task automatic half();
    repeat (8) @(negedge mclk);
  endtask : half
  // start or repeated start
  task automatic start();
    sda_drv = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_drv = 1'b0;
    half();
    scl = 1'b0;
    half();
  endtask : start
  task automatic stop();
    sda_drv = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_drv = 1'b1;
    half();
  endtask : stop
  // eight bits then the ninth; r holds the line at each clock high
  task automatic byte_i2c(input logic [7:0] d, input logic ack_in, output logic [8:0] r);
    logic [8:0] w;
    w = {d, ack_in};
    for (int i = 8; i >= 0; i--) begin
      sda_drv = w[i];
      half();
      scl = 1'b1;
      half();
      r[i] = sda_line;
      scl = 1'b0;
    end
  endtask : byte_i2c
  // four-wire byte: change at fall, device samples at rise
  task automatic spi(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      scl = 1'b0;
      sda_drv = d[i];
      half();
      q[i] = sdo_line;
      scl = 1'b1;
      half();
    end
  endtask : spi
  task automatic select(input logic lvl);
    cs_n = lvl;
    if (lvl) sda_drv = 1'b1;
    half();
  endtask : select
endmodule : srap_host

// ==== serial_register_access_port_test.sv ====
// self-checking bench of the serial register access port
// assumes srap_host drives the link; the register file is modelled here
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module serial_register_access_port_test;
  logic mclk, srst, scl, sda_drv, cs_n, ad_lvl, stall, reg_wr_ready;
  logic sda_out, sda_oe_n, sdo_out, sdo_oe_n, reg_wr_valid, wr_dropped, link_busy;
  logic [6:0] reg_wr_index, rd_index;
  logic [7:0] reg_wr_data, rd_data;
  logic [7:0] regs [128];
  logic [7:0] mdl [128];
  logic [14:0] expq [$];
  logic [14:0] exp_w;
  int n_fail, cmp_count, n_drop;
  // open-drain data with pull-up, shared address pin
  wire logic sda_line = sda_drv & (sda_oe_n | sda_out);
  wire logic sdo_line = sdo_oe_n ? ad_lvl : sdo_out;
  assign rd_data = regs[rd_index];
  srap_top u_dut (.mclk(mclk), .srst(srst), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .cs_n_in(cs_n), .address_select_pin(sdo_line),
    .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n), .reg_wr_valid(reg_wr_valid),
    .reg_wr_ready(reg_wr_ready), .reg_wr_index(reg_wr_index), .reg_wr_data(reg_wr_data),
    .rd_index(rd_index), .rd_data(rd_data), .wr_dropped(wr_dropped), .link_busy(link_busy));
  srap_host u_host (.mclk(mclk), .sda_line(sda_line), .sdo_line(sdo_line), .scl(scl),
    .sda_drv(sda_drv), .cs_n(cs_n));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // register file: random stalls, compare each taken word
  always @(negedge mclk) reg_wr_ready <= !stall && ($urandom % 4 != 0);
  always @(posedge mclk) begin
    if (!srst && reg_wr_valid === 1'b1 && reg_wr_ready) begin
      `CHK(expq.size() > 0, 1'b1)
      if (expq.size() > 0) begin
        exp_w = expq.pop_front();
        `CHK({reg_wr_index, reg_wr_data}, exp_w)
      end
      regs[reg_wr_index] <= reg_wr_data;
    end
    if (wr_dropped === 1'b1) n_drop++;
  end
  task automatic push(input int idx, input logic [7:0] d);
    expq.push_back({7'(idx), d});
    mdl[7'(idx)] = d;
  endtask : push
  task automatic drain();
    for (int t = 0; t < 2000 && expq.size() > 0; t++) @(negedge mclk);
  endtask : drain
  task automatic i2c_wr(input logic [6:0] idx, input int n);
    logic [8:0] r;
    logic [7:0] d;
    u_host.start();
    u_host.byte_i2c({srap_pkg::DEV_ADDR_HI, ad_lvl, 1'b0}, 1'b1, r);
    `CHK(r[0], 1'b0)
    u_host.byte_i2c({1'b0, idx}, 1'b1, r);
    `CHK(r[0], 1'b0)
    for (int k = 0; k < n; k++) begin
      d = 8'($urandom);
      push(idx + k, d);
      u_host.byte_i2c(d, 1'b1, r);
      `CHK(r[0], 1'b0)
    end
  endtask : i2c_wr
  task automatic i2c_rd(input logic [6:0] idx, input int n);
    logic [8:0] r;
    i2c_wr(idx, 0);
    u_host.start();
    u_host.byte_i2c({srap_pkg::DEV_ADDR_HI, ad_lvl, 1'b1}, 1'b1, r);
    `CHK(r[0], 1'b0)
    for (int k = 0; k < n; k++) begin
      u_host.byte_i2c(8'hff, k == n - 1, r);
      `CHK(r[8:1], mdl[7'(idx + k)])
    end
    u_host.stop();
    `CHK(sda_oe_n, 1'b1)
  endtask : i2c_rd
  task automatic spi_xfer(input logic rw, input logic [6:0] idx, input int n);
    logic [7:0] q;
    logic [7:0] d;
    u_host.select(1'b0);
    `CHK(sdo_oe_n, 1'b0)
    `CHK(link_busy, 1'b1)
    u_host.spi({rw, idx}, q);
    for (int k = 0; k < n; k++) begin
      d = 8'($urandom);
      if (!rw && (!stall || k < srap_pkg::FIFO_DEPTH)) push(idx + k, d);
      u_host.spi(d, q);
      if (rw) `CHK(q, mdl[7'(idx + k)])
    end
    u_host.select(1'b1);
    `CHK(sdo_oe_n, 1'b1)
    `CHK(link_busy, 1'b0)
  endtask : spi_xfer
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // hang guard, about four times the expected run of some 11k cycles
  initial begin
    #400000;
    n_fail++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    logic [8:0] r;
    srst = 1'b1;
    ad_lvl = 1'b0;
    stall = 1'b0;
    void'($urandom(60));
    for (int i = 0; i < 128; i++) begin
      regs[i] = 8'($urandom);
      mdl[i] = regs[i];
    end
    repeat (5) @(negedge mclk);
    srst = 1'b0;
    `CHK(sda_oe_n, 1'b1)
    `CHK(sdo_oe_n, 1'b1)
    repeat (3) @(negedge mclk);
    for (int a = 0; a < 2; a++) begin
      ad_lvl = a[0];
      i2c_wr(7'($urandom), 3);
      u_host.stop();
      i2c_wr(7'h7f, 2);
      u_host.stop();
      u_host.start();
      u_host.byte_i2c({srap_pkg::DEV_ADDR_HI, ~ad_lvl, 1'b0}, 1'b1, r);
      `CHK(r[0], 1'b1)
      u_host.stop();
      drain();
      i2c_rd(7'h7f, 2);
      i2c_rd(7'($urandom), 1);
    end
    ad_lvl = 1'b0;
    spi_xfer(1'b0, 7'h05, 3);
    spi_xfer(1'b0, 7'h7f, 1);
    drain();
    spi_xfer(1'b1, 7'h05, 3);
    spi_xfer(1'b1, 7'h7f, 1);
    stall = 1'b1;
    spi_xfer(1'b0, 7'h20, 10);
    `CHK(n_drop, 2)
    stall = 1'b0;
    drain();
    repeat (4) @(negedge mclk);
    `CHK(reg_wr_valid, 1'b0)
    spi_xfer(1'b1, 7'h20, 10);
    tally_and_finish();
  end
endmodule : serial_register_access_port_test
